// >>> design/dpbo_pkg.sv
// Constants, register map and state codes for the DPLL bandwidth and phase build-out control
package dpbo_pkg;

  // Register offsets (word index of the plain register port)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_BW_LOCKED = 4'h1;
  localparam logic [3:0] REG_BW_ACQ = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_OFFSET = 4'h4;
  localparam logic [3:0] REG_IRQ_STAT = 4'h5;
  localparam logic [3:0] REG_IRQ_MASK = 4'h6;

  // Control field positions and reset values
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_FREEZE_BIT = 1;
  localparam logic CTRL_ENABLE_RST = 1'b1;
  localparam logic CTRL_FREEZE_RST = 1'b0;

  // Bandwidth codes: 0 is the narrowest corner, 9 the widest
  localparam int BW_STEPS = 10;
  localparam logic [3:0] BW_CODE_MAX = 4'h9;
  localparam logic [3:0] BW_LOCKED_RST = 4'h2;
  localparam logic [3:0] BW_ACQ_RST = 4'h9;

  // Status field positions
  localparam int STAT_LOCK_BIT = 4;
  localparam int STAT_HOLD_BIT = 5;
  localparam int STAT_BW_LSB = 8;

  // Interrupt status bits
  localparam int IRQ_W = 5;
  localparam int IRQ_BUILDOUT_EVENT = 0;
  localparam int IRQ_BUILDOUT_DONE = 1;
  localparam int IRQ_LOCK_GAIN = 2;
  localparam int IRQ_LOCK_LOSS = 3;
  localparam int IRQ_BUILDOUT_SKIP = 4;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 5'h00;

  // Timing
  localparam int CLK_PERIOD_PS = 20000;
  localparam int SETTLE_TIME_NS = 1000;
  localparam int SETTLE_CYC = (SETTLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PHASE_LSB_PS = 100;
  localparam int TRANSIENT_MAX_PS = 5000;
  localparam int TRANSIENT_LSB = TRANSIENT_MAX_PS / PHASE_LSB_PS;

  // Build-out sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_HOLD = 4'b0010,
    ST_MEAS = 4'b0100,
    ST_LOAD = 4'b1000
  } dpbo_state_t;

endpackage

// >>> design/dpbo_phase_avg.sv
// Phase averager: mean of 2**LOG2N phase samples taken after a start strobe
`timescale 1ns/100ps
`default_nettype none
module dpbo_phase_avg #(
  parameter int PW = 16,
  parameter int LOG2N = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Control
  input wire logic start,
  input wire logic signed [PW-1:0] sample,
  // Result
  output logic busy,
  output logic done,
  output logic signed [PW-1:0] mean
);

  localparam int AW = PW + LOG2N;

  logic signed [AW-1:0] acc_reg;
  logic [LOG2N:0] cnt_reg;
  logic busy_reg;
  logic done_reg;
  logic signed [PW-1:0] mean_reg;
  logic last;
  logic signed [AW-1:0] acc_sum;
  logic signed [AW-1:0] acc_shift;

  // Last sample of the window and the running sum
  assign last = (cnt_reg == (LOG2N+1)'((1 << LOG2N) - 1));
  assign acc_sum = acc_reg + AW'(sample);
  assign acc_shift = acc_sum >>> LOG2N;

  // Sample window and mean register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      acc_reg <= '0;
      cnt_reg <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      mean_reg <= '0;
    end else begin
      done_reg <= busy_reg & last;
      if (start) begin
        acc_reg <= '0;
        cnt_reg <= '0;
        busy_reg <= 1'b1;
      end else if (busy_reg) begin
        acc_reg <= acc_sum;
        cnt_reg <= cnt_reg + (LOG2N+1)'(1);
        if (last) begin
          busy_reg <= 1'b0;
          mean_reg <= acc_shift[PW-1:0];
        end
      end
    end
  end

  assign busy = busy_reg;
  assign done = done_reg;
  assign mean = mean_reg;

endmodule
`default_nettype wire

// >>> design/dpbo_loop_ctrl.sv
// DPLL loop bandwidth selection and phase build-out sequencer
//
// Overview of operation
// - The loop bandwidth is one of ten codes from the narrowest 0.1 Hz to the widest 70 Hz corner.
// - The code handed to the loop filter swaps between acquisition and locked values without software.
// - The phase lock indication picks the locked setting outside a build-out, phase loss picks the acquisition setting.
// - Loss of the selected reference asks for the next priority reference and raises a build-out event.
// - A build-out event puts the loop into a temporary holdover before it follows the new reference.
// - During that holdover the new reference phase against the output clock is measured.
// - The measured difference is then loaded as a phase offset so the output does not jump.
// - After build-out the phase step presented to the loop stays within five nanoseconds.
// - Software enables, disables or freezes build-out over the register port; enabled after reset.
// - Freezing is accepted only with the enable bit set in the same write and keeps the offset in force at that moment.
// - While frozen, later reference switches raise no build-out and the held offset stays.
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module dpbo_loop_ctrl #(
  parameter int PW = 16,
  parameter int MEAS_LOG2N = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Reference monitor and selector
  input wire logic ref_lost,
  input wire logic phase_lock,
  output logic select_next,
  // Phase detector and loop filter
  input wire logic signed [PW-1:0] ref_phase_err,
  output logic signed [PW-1:0] loop_phase,
  output logic [3:0] bw_code,
  output logic temp_holdover,
  // Interrupt
  output logic irq
);

  generate
    if (PW < 8 || PW > 16 || MEAS_LOG2N < 1 || MEAS_LOG2N > 8) begin : g_bad_param
      $error("dpbo_loop_ctrl: PW must be 8..16 and MEAS_LOG2N 1..8");
    end
  endgenerate

  localparam logic [7:0] SETTLE_LAST = 8'(dpbo_pkg::SETTLE_CYC - 1);
  localparam logic signed [PW:0] LIM_POS = (PW+1)'(dpbo_pkg::TRANSIENT_LSB);
  localparam logic signed [PW:0] LIM_NEG = -(PW+1)'(dpbo_pkg::TRANSIENT_LSB);

  // A bandwidth code beyond the last step is refused
  function automatic logic bw_ok(input logic [15:0] d);
    bw_ok = (d[15:4] == 12'h000) && (d[3:0] <= dpbo_pkg::BW_CODE_MAX);
  endfunction

  // Registers
  logic ctrl_en_reg;
  logic ctrl_frz_reg;
  logic [3:0] bw_locked_reg;
  logic [3:0] bw_acq_reg;
  logic [dpbo_pkg::IRQ_W-1:0] irq_stat_reg;
  logic [dpbo_pkg::IRQ_W-1:0] irq_mask_reg;
  logic [15:0] rdata_reg;
  logic irq_reg;
  // Sequencer and loop outputs
  dpbo_pkg::dpbo_state_t state_reg;
  dpbo_pkg::dpbo_state_t state_next;
  logic [7:0] settle_reg;
  logic signed [PW-1:0] offset_reg;
  logic signed [PW-1:0] loop_phase_reg;
  logic [3:0] bw_code_reg;
  logic hold_reg;
  logic select_reg;
  logic lost_dly_reg;
  logic lock_dly_reg;

  // Decode of the register port
  logic wr_ctrl;
  logic wr_bwl;
  logic wr_bwa;
  logic wr_mask;
  logic rd_istat;
  assign wr_ctrl = reg_wr && (reg_addr == dpbo_pkg::REG_CTRL);
  assign wr_bwl = reg_wr && (reg_addr == dpbo_pkg::REG_BW_LOCKED) && bw_ok(reg_wdata);
  assign wr_bwa = reg_wr && (reg_addr == dpbo_pkg::REG_BW_ACQ) && bw_ok(reg_wdata);
  assign wr_mask = reg_wr && (reg_addr == dpbo_pkg::REG_IRQ_MASK);
  assign rd_istat = reg_rd && (reg_addr == dpbo_pkg::REG_IRQ_STAT);

  // Control write: freeze needs enable in the same word
  logic en_wdata;
  logic frz_wdata;
  assign en_wdata = reg_wdata[dpbo_pkg::CTRL_ENABLE_BIT];
  assign frz_wdata = reg_wdata[dpbo_pkg::CTRL_FREEZE_BIT] & en_wdata;

  // Build-out mode
  logic buildout_active;
  logic busy;
  assign buildout_active = ctrl_en_reg & ~ctrl_frz_reg;
  assign busy = (state_reg != dpbo_pkg::ST_IDLE);

  // Reference loss and lock edges
  logic lost_rise;
  logic buildout_event;
  logic buildout_skip;
  logic lock_gain;
  logic lock_loss;
  assign lost_rise = ref_lost & ~lost_dly_reg;
  assign buildout_event = lost_rise & buildout_active;
  assign buildout_skip = lost_rise & ~buildout_active;
  assign lock_gain = phase_lock & ~lock_dly_reg;
  assign lock_loss = ~phase_lock & lock_dly_reg;

  // Phase averager used as the measurement
  logic meas_start;
  logic meas_done;
  logic signed [PW-1:0] meas_mean;
  assign meas_start = (state_reg == dpbo_pkg::ST_HOLD) && (settle_reg == SETTLE_LAST) && buildout_active;

  dpbo_phase_avg #(
    .PW(PW),
    .LOG2N(MEAS_LOG2N)
  ) u_avg (
    .mclk(mclk),
    .rst(rst),
    .start(meas_start),
    .sample(ref_phase_err),
    .busy(),
    .done(meas_done),
    .mean(meas_mean)
  );

  // Sequencer next state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      dpbo_pkg::ST_IDLE: begin
        if (buildout_event) begin
          state_next = dpbo_pkg::ST_HOLD;
        end
      end
      dpbo_pkg::ST_HOLD: begin
        if (!buildout_active) begin
          state_next = dpbo_pkg::ST_IDLE;
        end else if (meas_start) begin
          state_next = dpbo_pkg::ST_MEAS;
        end
      end
      dpbo_pkg::ST_MEAS: begin
        if (!buildout_active) begin
          state_next = dpbo_pkg::ST_IDLE;
        end else if (buildout_event) begin
          state_next = dpbo_pkg::ST_HOLD;
        end else if (meas_done) begin
          state_next = dpbo_pkg::ST_LOAD;
        end
      end
      dpbo_pkg::ST_LOAD: begin
        state_next = buildout_event ? dpbo_pkg::ST_HOLD : dpbo_pkg::ST_IDLE;
      end
      default: begin
        state_next = dpbo_pkg::ST_IDLE;
      end
    endcase
  end

  // Offset source: cleared when disabled, loaded after measuring
  logic signed [PW-1:0] offset_next;
  assign offset_next = !ctrl_en_reg ? '0 :
                       (state_reg == dpbo_pkg::ST_LOAD && buildout_active) ? meas_mean :
                       offset_reg;

  // Residual phase after the offset, clamped to the transient limit
  logic signed [PW:0] resid;
  logic signed [PW:0] resid_lim;
  logic signed [PW-1:0] loop_phase_next;
  assign resid = (PW+1)'(ref_phase_err) - (PW+1)'(offset_reg);
  assign resid_lim = (resid > LIM_POS) ? LIM_POS : (resid < LIM_NEG) ? LIM_NEG : resid;
  assign loop_phase_next = hold_reg ? '0 :
                           !ctrl_en_reg ? ref_phase_err :
                           resid_lim[PW-1:0];

  // Bandwidth follows lock state; acquisition while holding over
  logic [3:0] bw_next;
  assign bw_next = (phase_lock && !busy) ? bw_locked_reg : bw_acq_reg;

  // Interrupt events, set wins over the read clear
  logic [dpbo_pkg::IRQ_W-1:0] irq_set;
  logic [dpbo_pkg::IRQ_W-1:0] irq_stat_next;
  assign irq_set = {buildout_skip, lock_loss, lock_gain,
                    (state_reg == dpbo_pkg::ST_LOAD) && buildout_active, buildout_event};
  assign irq_stat_next = (rd_istat ? '0 : irq_stat_reg) | irq_set;

  // Read data mux
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    unique case (reg_addr)
      dpbo_pkg::REG_CTRL: begin
        rd_mux[dpbo_pkg::CTRL_ENABLE_BIT] = ctrl_en_reg;
        rd_mux[dpbo_pkg::CTRL_FREEZE_BIT] = ctrl_frz_reg;
      end
      dpbo_pkg::REG_BW_LOCKED: begin
        rd_mux[3:0] = bw_locked_reg;
      end
      dpbo_pkg::REG_BW_ACQ: begin
        rd_mux[3:0] = bw_acq_reg;
      end
      dpbo_pkg::REG_STATUS: begin
        rd_mux[3:0] = state_reg;
        rd_mux[dpbo_pkg::STAT_LOCK_BIT] = phase_lock;
        rd_mux[dpbo_pkg::STAT_HOLD_BIT] = hold_reg;
        rd_mux[dpbo_pkg::STAT_BW_LSB +: 4] = bw_code_reg;
      end
      dpbo_pkg::REG_OFFSET: begin
        rd_mux[PW-1:0] = offset_reg;
      end
      dpbo_pkg::REG_IRQ_STAT: begin
        rd_mux[dpbo_pkg::IRQ_W-1:0] = irq_stat_reg;
      end
      dpbo_pkg::REG_IRQ_MASK: begin
        rd_mux[dpbo_pkg::IRQ_W-1:0] = irq_mask_reg;
      end
      default: begin
        rd_mux = 16'h0000;
      end
    endcase
  end

  // Software registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_en_reg <= dpbo_pkg::CTRL_ENABLE_RST;
      ctrl_frz_reg <= dpbo_pkg::CTRL_FREEZE_RST;
      bw_locked_reg <= dpbo_pkg::BW_LOCKED_RST;
      bw_acq_reg <= dpbo_pkg::BW_ACQ_RST;
      irq_mask_reg <= dpbo_pkg::IRQ_MASK_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_en_reg <= en_wdata;
        ctrl_frz_reg <= frz_wdata;
      end
      if (wr_bwl) begin
        bw_locked_reg <= reg_wdata[3:0];
      end
      if (wr_bwa) begin
        bw_acq_reg <= reg_wdata[3:0];
      end
      if (wr_mask) begin
        irq_mask_reg <= reg_wdata[dpbo_pkg::IRQ_W-1:0];
      end
    end
  end

  // Read data and interrupt
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 16'h0000;
      irq_stat_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      rdata_reg <= reg_rd ? rd_mux : 16'h0000;
      irq_stat_reg <= irq_stat_next;
      irq_reg <= |(irq_stat_next & irq_mask_reg);
    end
  end

  // Sequencer, settle timer and holdover flag
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= dpbo_pkg::ST_IDLE;
      settle_reg <= 8'h00;
      hold_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      settle_reg <= (state_next == dpbo_pkg::ST_HOLD && state_reg == dpbo_pkg::ST_HOLD && !buildout_event) ?
                    settle_reg + 8'h01 : 8'h00;
      hold_reg <= (state_next != dpbo_pkg::ST_IDLE);
    end
  end

  // Loop-facing outputs
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      offset_reg <= '0;
      loop_phase_reg <= '0;
      bw_code_reg <= dpbo_pkg::BW_ACQ_RST;
      select_reg <= 1'b0;
      lost_dly_reg <= 1'b0;
      lock_dly_reg <= 1'b0;
    end else begin
      offset_reg <= offset_next;
      loop_phase_reg <= loop_phase_next;
      bw_code_reg <= bw_next;
      select_reg <= lost_rise;
      lost_dly_reg <= ref_lost;
      lock_dly_reg <= phase_lock;
    end
  end

  assign reg_rdata = rdata_reg;
  assign select_next = select_reg;
  assign loop_phase = loop_phase_reg;
  assign bw_code = bw_code_reg;
  assign temp_holdover = hold_reg;
  assign irq = irq_reg;

endmodule
`default_nettype wire

// >>> bench/dpbo_loop_ctrl_monitor.sv
// Port-level checker for the loop bandwidth and build-out control
`timescale 1ns/100ps
`default_nettype none
module dpbo_loop_ctrl_monitor #(
  parameter int PW = 16,
  parameter int MEAS_LOG2N = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Reference side
  input wire logic ref_lost,
  input wire logic phase_lock,
  input wire logic select_next,
  // Loop side
  input wire logic signed [PW-1:0] ref_phase_err,
  input wire logic signed [PW-1:0] loop_phase,
  input wire logic [3:0] bw_code,
  input wire logic temp_holdover,
  input wire logic irq
);
  logic [7:0] hold_cnt_reg;
  logic [7:0] hold_cnt_next;

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  // Holdover length since the last loss, saturating
  assign hold_cnt_next = (select_next || !temp_holdover) ? 8'h00 :
                         (hold_cnt_reg == 8'hFF) ? hold_cnt_reg : hold_cnt_reg + 8'h01;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hold_cnt_reg <= 8'h00;
    end else begin
      hold_cnt_reg <= hold_cnt_next;
    end
  end

  // Port relations
  AST_SEL_NEXT: assert property ($rose(ref_lost) |=> select_next)
    else $error("select_next missing after reference loss");
  AST_SEL_SINGLE: assert property (select_next |=> !select_next)
    else $error("select_next longer than one cycle");
  AST_SEL_CAUSE: assert property (select_next |-> $past(ref_lost) && !$past(ref_lost, 2))
    else $error("select_next without a loss edge");
  AST_HOLD_CAUSE: assert property ($rose(temp_holdover) |-> select_next)
    else $error("holdover entered without a switch");
  AST_HOLD_MIN: assert property ($rose(temp_holdover) |-> temp_holdover [*8])
    else $error("holdover too short");
  AST_HOLD_BOUND: assert property (temp_holdover |-> hold_cnt_reg < 8'h50)
    else $error("holdover does not finish");
  AST_HOLD_LOOP: assert property (temp_holdover && $past(temp_holdover) |-> loop_phase == '0)
    else $error("loop follows input during holdover");
  AST_LOOP_CLAMP: assert property ((loop_phase > dpbo_pkg::TRANSIENT_LSB ||
    loop_phase < -dpbo_pkg::TRANSIENT_LSB) |-> loop_phase == $past(ref_phase_err))
    else $error("loop phase step beyond limit");
  AST_BW_RANGE: assert property (bw_code <= dpbo_pkg::BW_CODE_MAX)
    else $error("bandwidth code out of range");
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside its cycle");
  AST_IRQ_MASK: assert property (reg_wr && reg_addr == dpbo_pkg::REG_IRQ_MASK &&
    reg_wdata[dpbo_pkg::IRQ_W-1:0] == '0 |=> ##1 !irq)
    else $error("interrupt stays high with all sources masked");

  // Main scenarios
  CV_BUILDOUT: cover property ($fell(temp_holdover));
  CV_SKIP: cover property (select_next && !temp_holdover);
  CV_CLAMP: cover property (loop_phase == dpbo_pkg::TRANSIENT_LSB);
endmodule

bind dpbo_loop_ctrl dpbo_loop_ctrl_monitor #(.PW(PW), .MEAS_LOG2N(MEAS_LOG2N)) u_monitor (
  .mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ref_lost, .phase_lock,
  .select_next, .ref_phase_err, .loop_phase, .bw_code, .temp_holdover, .irq);
`default_nettype wire

// >>> bench/test_dpbo_loop_ctrl.sv
// Self-checking testbench for the loop bandwidth and build-out control
`timescale 1ns/100ps
`default_nettype none
module test_dpbo_loop_ctrl;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic ref_lost = 1'b0;
  logic phase_lock = 1'b0;
  logic signed [15:0] ref_phase_err = 16'h0000;
  logic [15:0] reg_rdata;
  logic select_next;
  logic temp_holdover;
  logic irq;
  logic signed [15:0] loop_phase;
  logic [3:0] bw_code;
  logic [15:0] rd_val;
  int err_total = 0;
  int num_checks = 0;

  // Block under test
  dpbo_loop_ctrl u_dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ref_lost(ref_lost),
    .phase_lock(phase_lock), .select_next(select_next), .ref_phase_err(ref_phase_err),
    .loop_phase(loop_phase), .bw_code(bw_code), .temp_holdover(temp_holdover), .irq(irq));

  // 50 MHz clock
  always #10 mclk = ~mclk;

  // Compare one value
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Register write and read cycles
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Loss of the selected reference
  task automatic lose(input logic hold);
    @(posedge mclk);
    ref_lost <= 1'b1;
    tick(1);
    chk("select_next", 16'h0001, 16'(select_next));
    chk("temp_holdover", 16'(hold), 16'(temp_holdover));
    @(posedge mclk);
    ref_lost <= 1'b0;
  endtask

  task automatic set_err(input logic [15:0] e);
    @(posedge mclk);
    ref_phase_err <= e;
    tick(2);
  endtask

  // Verdict and end of run
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (5000) @(posedge mclk);
    err_total++;
    give_verdict();
  end

  // Test sequence
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    rd(dpbo_pkg::REG_CTRL);
    chk("ctrl", 16'h0001, rd_val);
    rd(dpbo_pkg::REG_BW_LOCKED);
    chk("bw_locked", 16'h0002, rd_val);
    rd(dpbo_pkg::REG_BW_ACQ);
    chk("bw_acq", 16'h0009, rd_val);
    rd(4'h7);
    chk("unmapped", 16'h0000, rd_val);
    chk("bw_code", 16'h0009, 16'(bw_code));
    $display("reset test done");
    @(posedge mclk);
    phase_lock <= 1'b1;
    for (int c = 0; c < 10; c++) begin
      wr(dpbo_pkg::REG_BW_LOCKED, 16'(c));
      tick(2);
      chk("bw_code locked", 16'(c), 16'(bw_code));
    end
    wr(dpbo_pkg::REG_BW_LOCKED, 16'h000A);
    wr(dpbo_pkg::REG_BW_ACQ, 16'h0005);
    @(posedge mclk);
    phase_lock <= 1'b0;
    tick(2);
    chk("bw_code acq", 16'h0005, 16'(bw_code));
    @(posedge mclk);
    phase_lock <= 1'b1;
    tick(2);
    chk("bw_code relock", 16'h0009, 16'(bw_code));
    $display("bandwidth test done");
    wr(dpbo_pkg::REG_IRQ_MASK, 16'h001F);
    rd(dpbo_pkg::REG_IRQ_STAT);
    chk("irq_stat lock", 16'h000C, rd_val);
    set_err(16'h001E);
    lose(1'b1);
    tick(1);
    chk("bw_code hold", 16'h0005, 16'(bw_code));
    chk("irq", 16'h0001, 16'(irq));
    rd(dpbo_pkg::REG_STATUS);
    chk("status hold", 16'h0532, rd_val);
    for (int i = 0; i < 200 && temp_holdover; i++) tick(1);
    chk("holdover end", 16'h0000, 16'(temp_holdover));
    rd(dpbo_pkg::REG_OFFSET);
    chk("offset", 16'h001E, rd_val);
    set_err(16'h0028);
    chk("loop_phase", 16'h000A, loop_phase);
    set_err(16'h00A0);
    chk("loop clamp hi", 16'h0032, loop_phase);
    set_err(16'hFF38);
    chk("loop clamp lo", 16'hFFCE, loop_phase);
    rd(dpbo_pkg::REG_IRQ_STAT);
    chk("irq_stat", 16'h0003, rd_val);
    tick(1);
    chk("irq cleared", 16'h0000, 16'(irq));
    $display("build-out test done");
    wr(dpbo_pkg::REG_CTRL, 16'h0003);
    rd(dpbo_pkg::REG_CTRL);
    chk("ctrl frozen", 16'h0003, rd_val);
    lose(1'b0);
    rd(dpbo_pkg::REG_OFFSET);
    chk("offset held", 16'h001E, rd_val);
    rd(dpbo_pkg::REG_IRQ_STAT);
    chk("stat frozen", 16'h0010, rd_val & 16'h0012);
    $display("freeze test done");
    wr(dpbo_pkg::REG_IRQ_MASK, 16'h0000);
    wr(dpbo_pkg::REG_CTRL, 16'h0002);
    rd(dpbo_pkg::REG_CTRL);
    chk("freeze refused", 16'h0000, rd_val);
    lose(1'b0);
    tick(2);
    chk("irq masked", 16'h0000, 16'(irq));
    rd(dpbo_pkg::REG_OFFSET);
    chk("offset cleared", 16'h0000, rd_val);
    set_err(16'h0200);
    chk("loop direct", 16'h0200, loop_phase);
    rd(dpbo_pkg::REG_IRQ_STAT);
    chk("stat disabled", 16'h0010, rd_val & 16'h0012);
    $display("disable test done");
    give_verdict();
  end
endmodule
`default_nettype wire
